/* File: logic/dtiu_top.sv */
// dtiu_top: data transfer instructions with exact clock counts and bus transfers
// assumes same-clock memory, read data the cycle after the strobe,
// and one decoded instruction offered at a time
//
// Notes on behaviour
// - register to memory: bytes 9 clocks, split words 13, else 9; one transfer
// - memory to register: bytes 11 clocks, split words 15, else 11
// - immediate to memory: one transfer; bytes 11 clocks, split words 15, else 11
// - immediate to register: 4 clocks, no bus transfer
// - accumulator load from direct address: low byte first, high next; 10 or 14
// - accumulator store to direct address: low at address, high next; 9 or 13
// - segment load from register: never program segment; 2 clocks, no bus
// - after segment load from register, interrupts and single step blocked one instruction
// - segment load from memory: same blocking; one transfer; 15 or 11 clocks
// - segment register to general register: 2 clocks, no bus
// - segment register to memory: one transfer; 14 or 10 clocks
// - pointer load: offset word to register, next word to data segment zero; 26 or 18
// - same pointer load into data segment one
// - flags to accumulator high: sign, zero, aux carry, parity, carry; 2 clocks
// - accumulator high bits 7,6,4,2,0 to flags, overflow kept; 3 clocks
// - effective address load writes offset, not memory; 4 clocks, no bus
// - table lookup reads byte at base word plus accumulator low; 9 clocks
// - register exchange swaps two registers in 3 clocks, no bus
// - memory exchange: two transfers; bytes 16, split words 24, else 16
// - accumulator word exchange with register: 3 clocks, no bus
// - word bit one selects word operand, zero selects byte
// - segment selector 00 data one, 01 program, 10 stack, 11 data zero
// - operand offset from addressing form, base field and displacement
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module dtiu_top #(
  parameter bit NARROW_BUS = 1'b0
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic op_valid,
  input dtiu_pkg::dtiu_op_s op,
  output logic op_ready,
  output logic op_done,
  output logic irq_inhibit,
  output dtiu_pkg::dtiu_mem_s mem_out,
  input wire logic [15:0] mem_rdata,
  input wire logic [3:0] rb_addr,
  input wire logic [15:0] rb_wdata,
  input wire logic rb_wr,
  input wire logic rb_rd,
  output logic [15:0] rb_rdata
);
`include "dtiu_cfg.svh"

  dtiu_pkg::dtiu_state_e state_q, state_d;
  logic [4:0] cnt_q;
  dtiu_pkg::dtiu_op_s op_q;
  logic [31:0] rd_q, rd_d;
  logic [3:0][15:0] seg_q;
  logic [15:0] flags_q;
  logic inhibit_q;
  dtiu_pkg::dtiu_mem_s mem_q, mem_d;
  logic [15:0] rb_rdata_q;
  logic [7:0][15:0] gpr;
  logic [15:0] ea;
  logic bp_based;

  // register read by code; w=0 picks a byte half
  function automatic logic [15:0] get_reg(input logic [7:0][15:0] g, input logic [2:0] c,
                                          input logic w);
    logic [15:0] r;
    r = 16'h0000;
    if (w) begin
      r = g[c];
    end else begin
      r = c[2] ? {8'h00, g[c[1:0]][15:8]} : {8'h00, g[c[1:0]][7:0]};
    end
    return r;
  endfunction

  // k-th bus access of the running instruction
  function automatic dtiu_pkg::dtiu_acc_s acc_at(input logic [3:0] k, input logic [1:0] n_xfer,
                                                 input logic split, input logic word_acc,
                                                 input logic wr_only, input logic xchg,
                                                 input logic ptr);
    dtiu_pkg::dtiu_acc_s a;
    logic [3:0] t;
    a = '0;
    t = split ? {1'b0, k[3:1]} : k;
    a.valid = t < {2'h0, n_xfer};
    a.part = split & k[0];
    a.word = word_acc & !split;
    a.wr = wr_only | (xchg & t[0]);
    a.second = ptr & t[0];
    a.bidx = {ptr & t[0], a.part};
    return a;
  endfunction

  function automatic logic [4:0] clocks_for(input dtiu_pkg::dtiu_kind_e kind, input logic split);
    logic [4:0] c;
    case (kind)
      dtiu_pkg::DTIU_OP_MOV_MR: c = split ? `DTIU_CLK_ST_SPLIT : `DTIU_CLK_ST;
      dtiu_pkg::DTIU_OP_MOV_RM: c = split ? `DTIU_CLK_LD_SPLIT : `DTIU_CLK_LD;
      dtiu_pkg::DTIU_OP_MOV_MI: c = split ? `DTIU_CLK_LD_SPLIT : `DTIU_CLK_LD;
      dtiu_pkg::DTIU_OP_MOV_RI: c = `DTIU_CLK_REG4;
      dtiu_pkg::DTIU_OP_MOV_AD: c = split ? `DTIU_CLK_ACC_LD_SPLIT : `DTIU_CLK_ACC_LD;
      dtiu_pkg::DTIU_OP_MOV_DA: c = split ? `DTIU_CLK_ST_SPLIT : `DTIU_CLK_ST;
      dtiu_pkg::DTIU_OP_MOV_SM: c = split ? `DTIU_CLK_LD_SPLIT : `DTIU_CLK_LD;
      dtiu_pkg::DTIU_OP_MOV_MS: c = split ? `DTIU_CLK_SEG_ST_SPLIT : `DTIU_CLK_SEG_ST;
      dtiu_pkg::DTIU_OP_PTR_DS0: c = split ? `DTIU_CLK_PTR_SPLIT : `DTIU_CLK_PTR;
      dtiu_pkg::DTIU_OP_PTR_DS1: c = split ? `DTIU_CLK_PTR_SPLIT : `DTIU_CLK_PTR;
      dtiu_pkg::DTIU_OP_FLAGS_AH: c = `DTIU_CLK_REG3;
      dtiu_pkg::DTIU_OP_LOAD_EFFECTIVE_ADDRESS_OP: c = `DTIU_CLK_REG4;
      dtiu_pkg::DTIU_OP_LOOKUP: c = `DTIU_CLK_LOOKUP;
      dtiu_pkg::DTIU_OP_XCH_RR: c = `DTIU_CLK_REG3;
      dtiu_pkg::DTIU_OP_XCH_MR: c = split ? `DTIU_CLK_XCH_SPLIT : `DTIU_CLK_XCH;
      dtiu_pkg::DTIU_OP_XCH_AR: c = `DTIU_CLK_REG3;
      default: c = `DTIU_CLK_REG2;
    endcase
    return c;
  endfunction

  // instruction classes
  wire dtiu_pkg::dtiu_kind_e kind = op_q.kind;
  wire k_ptr = (kind == dtiu_pkg::DTIU_OP_PTR_DS0) || (kind == dtiu_pkg::DTIU_OP_PTR_DS1);
  wire k_xm = kind == dtiu_pkg::DTIU_OP_XCH_MR;
  wire k_dmem = (kind == dtiu_pkg::DTIU_OP_MOV_AD) || (kind == dtiu_pkg::DTIU_OP_MOV_DA);
  wire k_lookup = kind == dtiu_pkg::DTIU_OP_LOOKUP;
  wire k_wr_only = (kind == dtiu_pkg::DTIU_OP_MOV_MR) || (kind == dtiu_pkg::DTIU_OP_MOV_MI) ||
                   (kind == dtiu_pkg::DTIU_OP_MOV_DA) || (kind == dtiu_pkg::DTIU_OP_MOV_MS);
  wire k_rd = (kind == dtiu_pkg::DTIU_OP_MOV_RM) || (kind == dtiu_pkg::DTIU_OP_MOV_AD) ||
              (kind == dtiu_pkg::DTIU_OP_MOV_SM) || k_lookup || k_ptr || k_xm;
  wire k_seg_word = (kind == dtiu_pkg::DTIU_OP_MOV_SM) || (kind == dtiu_pkg::DTIU_OP_MOV_MS) || k_ptr;
  wire [1:0] n_xfer = (k_ptr || k_xm) ? 2'h2 : ((k_wr_only || k_rd) ? 2'h1 : 2'h0);
  wire word_acc = k_seg_word ? 1'b1 : (k_lookup ? 1'b0 : op_q.w);

  dtiu_ea u_ea (
    .mode(op_q.mode),
    .mem(op_q.mem),
    .disp(op_q.disp),
    .gpr(gpr),
    .ea(ea),
    .bp_based(bp_based)
  );

  // offset and segment of the memory operand
  wire [15:0] lookup_ofs = gpr[`DTIU_REG_BASE_WORD] + {8'h00, gpr[`DTIU_REG_ACC][7:0]};
  wire [15:0] mem_ofs = k_dmem ? op_q.disp : (k_lookup ? lookup_ofs : ea);
  wire [1:0] seg_sel = op_q.ovr_en ? op_q.ovr_seg :
                       ((bp_based && !k_dmem && !k_lookup) ? `DTIU_SEG_SS : `DTIU_SEG_DS0);
  wire split = word_acc && (NARROW_BUS || mem_ofs[0]);
  wire [4:0] clk_need = clocks_for(kind, split);

  // issue is registered: decided one cycle ahead on the next count
  wire [4:0] cnt_nxt = cnt_q + 5'h01;
  wire busy = state_q == dtiu_pkg::DTIU_ST_EXEC;
  wire dtiu_pkg::dtiu_acc_s acc_i = acc_at(cnt_nxt[4:1], n_xfer, split, word_acc, k_wr_only, k_xm, k_ptr);
  wire issue = busy && cnt_nxt[0] && acc_i.valid && (cnt_nxt < clk_need);
  wire [15:0] acc_ofs = mem_ofs + {14'h0000, acc_i.second, acc_i.part};
  wire [19:0] acc_addr = {seg_q[seg_sel], 4'h0} + {4'h0, acc_ofs};

  // data going out
  wire [15:0] reg_src = get_reg(gpr, op_q.rfield, op_q.w);
  wire [15:0] acc_src = op_q.w ? gpr[`DTIU_REG_ACC] : {8'h00, gpr[`DTIU_REG_ACC][7:0]};
  wire [15:0] wsrc = (kind == dtiu_pkg::DTIU_OP_MOV_MI) ? op_q.imm :
                     (kind == dtiu_pkg::DTIU_OP_MOV_DA) ? acc_src :
                     (kind == dtiu_pkg::DTIU_OP_MOV_MS) ? seg_q[op_q.sreg] : reg_src;
  wire [15:0] wbyte = acc_i.part ? {8'h00, wsrc[15:8]} : {8'h00, wsrc[7:0]};

  always_comb begin
    mem_d = '0;
    if (issue) begin
      mem_d.rd = !acc_i.wr;
      mem_d.wr = acc_i.wr;
      mem_d.word = acc_i.word;
      mem_d.addr = acc_addr;
      mem_d.wdata = acc_i.word ? wsrc : wbyte;
    end
  end

  // capture read data the cycle after each read strobe
  wire [3:0] cap_k = cnt_q[4:1] - 4'h1;
  wire dtiu_pkg::dtiu_acc_s acc_c = acc_at(cap_k, n_xfer, split, word_acc, k_wr_only, k_xm, k_ptr);
  wire capture = busy && !cnt_q[0] && (cnt_q != 5'h00) && acc_c.valid && !acc_c.wr;

  always_comb begin
    rd_d = rd_q;
    if (capture) begin
      case ({acc_c.word, acc_c.bidx})
        3'h4: rd_d[15:0] = mem_rdata;
        3'h6: rd_d[31:16] = mem_rdata;
        3'h0: rd_d[7:0] = mem_rdata[7:0];
        3'h1: rd_d[15:8] = mem_rdata[7:0];
        3'h2: rd_d[23:16] = mem_rdata[7:0];
        3'h3: rd_d[31:24] = mem_rdata[7:0];
        default: rd_d = rd_q;
      endcase
    end
  end

  wire done = busy && (cnt_q == clk_need - 5'h01);
  assign op_ready = !busy;
  assign op_done = done;

  // writeback at the last clock of the instruction
  dtiu_pkg::dtiu_gpr_wr_s wb_a, wb_b, port_a;
  logic seg_we;
  logic [1:0] seg_idx;
  logic [15:0] seg_data;
  logic flags_we;
  logic inhibit_set;

  always_comb begin
    wb_a = '0;
    wb_b = '0;
    seg_we = 1'b0;
    seg_idx = op_q.sreg;
    seg_data = 16'h0000;
    flags_we = 1'b0;
    inhibit_set = 1'b0;
    wb_a.code = op_q.rfield;
    wb_a.w = op_q.w;
    case (kind)
      dtiu_pkg::DTIU_OP_MOV_RR: begin
        wb_a.en = 1'b1;
        wb_a.data = get_reg(gpr, op_q.mem, op_q.w);
      end
      dtiu_pkg::DTIU_OP_MOV_RM, dtiu_pkg::DTIU_OP_XCH_MR: begin
        wb_a.en = 1'b1;
        wb_a.data = rd_q[15:0];
      end
      dtiu_pkg::DTIU_OP_MOV_RI: begin
        wb_a.en = 1'b1;
        wb_a.data = op_q.imm;
      end
      dtiu_pkg::DTIU_OP_MOV_AD, dtiu_pkg::DTIU_OP_LOOKUP: begin
        wb_a.en = 1'b1;
        wb_a.code = `DTIU_REG_ACC;
        wb_a.w = op_q.w && k_dmem;
        wb_a.data = rd_q[15:0];
      end
      dtiu_pkg::DTIU_OP_MOV_SR: begin
        seg_we = op_q.sreg != `DTIU_SEG_PS;
        seg_data = gpr[op_q.rfield];
        inhibit_set = seg_we;
      end
      dtiu_pkg::DTIU_OP_MOV_SM: begin
        seg_we = op_q.sreg != `DTIU_SEG_PS;
        seg_data = rd_q[15:0];
        inhibit_set = seg_we;
      end
      dtiu_pkg::DTIU_OP_MOV_RS: begin
        wb_a.en = 1'b1;
        wb_a.w = 1'b1;
        wb_a.data = seg_q[op_q.sreg];
      end
      dtiu_pkg::DTIU_OP_PTR_DS0, dtiu_pkg::DTIU_OP_PTR_DS1: begin
        wb_a.en = 1'b1;
        wb_a.w = 1'b1;
        wb_a.data = rd_q[15:0];
        seg_we = 1'b1;
        seg_idx = k_ptr && kind == dtiu_pkg::DTIU_OP_PTR_DS0 ? `DTIU_SEG_DS0 : `DTIU_SEG_DS1;
        seg_data = rd_q[31:16];
      end
      dtiu_pkg::DTIU_OP_AH_FLAGS: begin
        wb_a.en = 1'b1;
        wb_a.code = `DTIU_REG_ACC_HIGH;
        wb_a.w = 1'b0;
        wb_a.data = {8'h00, flags_q[7:0]};
      end
      dtiu_pkg::DTIU_OP_FLAGS_AH: flags_we = 1'b1;
      dtiu_pkg::DTIU_OP_LOAD_EFFECTIVE_ADDRESS_OP: begin
        wb_a.en = 1'b1;
        wb_a.w = 1'b1;
        wb_a.data = ea;
      end
      dtiu_pkg::DTIU_OP_XCH_RR: begin
        wb_a.en = 1'b1;
        wb_a.data = get_reg(gpr, op_q.mem, op_q.w);
        wb_b.en = 1'b1;
        wb_b.code = op_q.mem;
        wb_b.w = op_q.w;
        wb_b.data = reg_src;
      end
      dtiu_pkg::DTIU_OP_XCH_AR: begin
        wb_a.en = 1'b1;
        wb_a.code = `DTIU_REG_ACC;
        wb_a.w = 1'b1;
        wb_a.data = gpr[op_q.rfield];
        wb_b.en = 1'b1;
        wb_b.code = op_q.rfield;
        wb_b.w = 1'b1;
        wb_b.data = gpr[`DTIU_REG_ACC];
      end
      default: wb_a.en = 1'b0;
    endcase
  end

  // software writes registers only while idle, so it never races a writeback
  wire sw_gpr_we = rb_wr && !busy && rb_addr <= `DTIU_RB_GPR_LAST;
  wire sw_seg_we = rb_wr && !busy && rb_addr >= `DTIU_RB_SEG_BASE && rb_addr <= `DTIU_RB_SEG_LAST;
  wire sw_flags_we = rb_wr && !busy && rb_addr == `DTIU_RB_FLAGS;

  always_comb begin
    port_a = '0;
    if (done) begin
      port_a = wb_a;
    end else if (sw_gpr_we) begin
      port_a.en = 1'b1;
      port_a.code = rb_addr[2:0];
      port_a.w = 1'b1;
      port_a.data = rb_wdata;
    end
  end

  dtiu_regfile u_regfile (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr_a(port_a),
    .wr_b(done ? wb_b : '0),
    .gpr(gpr)
  );

  // overflow and every other flag kept; only five positions load
  wire [7:0] ah = gpr[`DTIU_REG_ACC][15:8];
  wire [15:0] flags_from_ah = {flags_q[15:8], ah[`DTIU_FLAG_S], ah[`DTIU_FLAG_Z], flags_q[5],
                               ah[`DTIU_FLAG_AC], flags_q[3], ah[`DTIU_FLAG_P], flags_q[1],
                               ah[`DTIU_FLAG_CY]};

  assign state_d = (op_valid && !busy) ? dtiu_pkg::DTIU_ST_EXEC :
                   (done ? dtiu_pkg::DTIU_ST_IDLE : state_q);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= dtiu_pkg::DTIU_ST_IDLE;
      cnt_q <= 5'h00;
      op_q <= '0;
      rd_q <= 32'h0000_0000;
      mem_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= busy ? cnt_nxt : 5'h00;
      op_q <= (op_valid && !busy) ? op : op_q;
      rd_q <= rd_d;
      mem_q <= mem_d;
    end
  end

  genvar gs;
  generate
    for (gs = 0; gs < 4; gs++) begin : g_seg
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          seg_q[gs] <= `DTIU_SEG_RST;
        end else if (done && seg_we && seg_idx == 2'(gs)) begin
          seg_q[gs] <= seg_data;
        end else if (sw_seg_we && rb_addr[1:0] == 2'(gs)) begin
          seg_q[gs] <= rb_wdata;
        end
      end
    end
  endgenerate

  // the blocking window lasts through the whole next instruction
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= `DTIU_FLAGS_RST;
      inhibit_q <= 1'b0;
    end else begin
      flags_q <= (done && flags_we) ? flags_from_ah : (sw_flags_we ? rb_wdata : flags_q);
      inhibit_q <= done ? inhibit_set : inhibit_q;
    end
  end

  wire [15:0] status = {13'h0000, NARROW_BUS, inhibit_q, busy};
  wire [15:0] rb_sel = (rb_addr <= `DTIU_RB_GPR_LAST) ? gpr[rb_addr[2:0]] :
                       (rb_addr <= `DTIU_RB_SEG_LAST) ? seg_q[rb_addr[1:0]] :
                       (rb_addr == `DTIU_RB_FLAGS) ? flags_q :
                       (rb_addr == `DTIU_RB_STATUS) ? status : 16'h0000;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rb_rdata_q <= 16'h0000;
    end else begin
      rb_rdata_q <= rb_rd ? rb_sel : 16'h0000;
    end
  end

  assign rb_rdata = rb_rdata_q;
  assign mem_out = mem_q;
  assign irq_inhibit = inhibit_q;

endmodule // dtiu_top

/* File: logic/dtiu_cfg.svh */
// dtiu_cfg.svh: offsets, fields, reset values and clock counts
// assumes inclusion by dtiu_top and dtiu_regfile; definitions only
`ifndef DTIU_CFG_SVH
`define DTIU_CFG_SVH

// software register port, word indices
`define DTIU_RB_GPR_LAST 4'h7
`define DTIU_RB_SEG_BASE 4'h8
`define DTIU_RB_SEG_LAST 4'hB
`define DTIU_RB_FLAGS 4'hC
`define DTIU_RB_STATUS 4'hD

// segment selector codes
`define DTIU_SEG_DS1 2'h0
`define DTIU_SEG_PS 2'h1
`define DTIU_SEG_SS 2'h2
`define DTIU_SEG_DS0 2'h3

// general register codes used implicitly
`define DTIU_REG_ACC 3'h0
`define DTIU_REG_ACC_HIGH 3'h4
`define DTIU_REG_BASE_WORD 3'h3

// flag word bit positions
`define DTIU_FLAG_CY 0
`define DTIU_FLAG_P 2
`define DTIU_FLAG_AC 4
`define DTIU_FLAG_Z 6
`define DTIU_FLAG_S 7

// reset values
`define DTIU_GPR_RST 16'h0000
`define DTIU_SEG_RST 16'h0000
`define DTIU_FLAGS_RST 16'h0000

// clock counts per variant: aligned or byte, then split word
`define DTIU_CLK_REG2 5'h02
`define DTIU_CLK_REG3 5'h03
`define DTIU_CLK_REG4 5'h04
`define DTIU_CLK_ST 5'h09
`define DTIU_CLK_ST_SPLIT 5'h0D
`define DTIU_CLK_LD 5'h0B
`define DTIU_CLK_LD_SPLIT 5'h0F
`define DTIU_CLK_ACC_LD 5'h0A
`define DTIU_CLK_ACC_LD_SPLIT 5'h0E
`define DTIU_CLK_SEG_ST 5'h0A
`define DTIU_CLK_SEG_ST_SPLIT 5'h0E
`define DTIU_CLK_PTR 5'h12
`define DTIU_CLK_PTR_SPLIT 5'h1A
`define DTIU_CLK_LOOKUP 5'h09
`define DTIU_CLK_XCH 5'h10
`define DTIU_CLK_XCH_SPLIT 5'h18

`endif

/* File: logic/dtiu_pkg.sv */
// dtiu_pkg: types of the data transfer unit
// assumes nothing beyond a SystemVerilog compiler
package dtiu_pkg;

  typedef enum logic [4:0] {
    DTIU_OP_MOV_RR = 5'h00,
    DTIU_OP_MOV_MR = 5'h01,
    DTIU_OP_MOV_RM = 5'h02,
    DTIU_OP_MOV_MI = 5'h03,
    DTIU_OP_MOV_RI = 5'h04,
    DTIU_OP_MOV_AD = 5'h05,
    DTIU_OP_MOV_DA = 5'h06,
    DTIU_OP_MOV_SR = 5'h07,
    DTIU_OP_MOV_SM = 5'h08,
    DTIU_OP_MOV_RS = 5'h09,
    DTIU_OP_MOV_MS = 5'h0A,
    DTIU_OP_PTR_DS0 = 5'h0B,
    DTIU_OP_PTR_DS1 = 5'h0C,
    DTIU_OP_AH_FLAGS = 5'h0D,
    DTIU_OP_FLAGS_AH = 5'h0E,
    DTIU_OP_LOAD_EFFECTIVE_ADDRESS_OP = 5'h0F,
    DTIU_OP_LOOKUP = 5'h10,
    DTIU_OP_XCH_RR = 5'h11,
    DTIU_OP_XCH_MR = 5'h12,
    DTIU_OP_XCH_AR = 5'h13
  } dtiu_kind_e;

  typedef enum logic [0:0] {
    DTIU_ST_IDLE = 1'b0,
    DTIU_ST_EXEC = 1'b1
  } dtiu_state_e;

  typedef struct packed {
    dtiu_kind_e kind;
    logic w;
    logic [2:0] rfield;
    logic [1:0] mode;
    logic [2:0] mem;
    logic [1:0] sreg;
    logic ovr_en;
    logic [1:0] ovr_seg;
    logic [15:0] disp;
    logic [15:0] imm;
  } dtiu_op_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } dtiu_mem_s;

  typedef struct packed {
    logic en;
    logic [2:0] code;
    logic w;
    logic [15:0] data;
  } dtiu_gpr_wr_s;

  typedef struct packed {
    logic valid;
    logic wr;
    logic word;
    logic part;
    logic second;
    logic [1:0] bidx;
  } dtiu_acc_s;

endpackage

/* File: logic/dtiu_regfile.sv */
// dtiu_regfile: eight general registers, byte halves, two write ports
// assumes the two ports never name the same register in one cycle
`timescale 1ns/100ps
module dtiu_regfile (
  input wire logic sys_clk,
  input wire logic arst_n,
  input dtiu_pkg::dtiu_gpr_wr_s wr_a,
  input dtiu_pkg::dtiu_gpr_wr_s wr_b,
  output logic [7:0][15:0] gpr
);
`include "dtiu_cfg.svh"

  logic [7:0][15:0] gpr_q;

  // byte codes 0-3 are low halves of words 0-3, codes 4-7 their high halves
  function automatic logic [15:0] merge(input logic [15:0] old, input dtiu_pkg::dtiu_gpr_wr_s p,
                                        input logic [2:0] idx);
    logic [15:0] r;
    r = old;
    if (p.en && p.w && p.code == idx) begin
      r = p.data;
    end else if (p.en && !p.w && idx[2] == 1'b0 && p.code[1:0] == idx[1:0]) begin
      r = p.code[2] ? {p.data[7:0], old[7:0]} : {old[15:8], p.data[7:0]};
    end
    return r;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_reg
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          gpr_q[gi] <= `DTIU_GPR_RST;
        end else begin
          gpr_q[gi] <= merge(merge(gpr_q[gi], wr_a, 3'(gi)), wr_b, 3'(gi));
        end
      end
    end
  endgenerate

  assign gpr = gpr_q;

endmodule // dtiu_regfile

/* File: logic/dtiu_ea.sv */
// dtiu_ea: operand offset from addressing form, base field and displacement
// assumes register values stable while an instruction runs
`timescale 1ns/100ps
module dtiu_ea (
  input wire logic [1:0] mode,
  input wire logic [2:0] mem,
  input wire logic [15:0] disp,
  input wire logic [7:0][15:0] gpr,
  output logic [15:0] ea,
  output logic bp_based
);

  logic [15:0] base_sum;
  logic [15:0] disp_ext;
  logic direct;

  // word 3 base, 5 base pointer, 6 source index, 7 dest index
  always_comb begin
    case (mem)
      3'h0: base_sum = gpr[3] + gpr[6];
      3'h1: base_sum = gpr[3] + gpr[7];
      3'h2: base_sum = gpr[5] + gpr[6];
      3'h3: base_sum = gpr[5] + gpr[7];
      3'h4: base_sum = gpr[6];
      3'h5: base_sum = gpr[7];
      3'h6: base_sum = gpr[5];
      default: base_sum = gpr[3];
    endcase
  end

  assign direct = (mode == 2'h0) && (mem == 3'h6);
  assign disp_ext = (mode == 2'h1) ? {{8{disp[7]}}, disp[7:0]} : ((mode == 2'h2) ? disp : 16'h0000);
  assign ea = direct ? disp : base_sum + disp_ext;
  assign bp_based = !direct && (mem == 3'h2 || mem == 3'h3 || mem == 3'h6);

endmodule // dtiu_ea

/* File: tb/dtiu_mem_model.sv */
// dtiu_mem_model: zero-wait byte memory on the unit's bus
// assumes one access strobe per cycle, low 10 address bits decoded
`timescale 1ns/100ps
module dtiu_mem_model (
  input wire logic sys_clk,
  input dtiu_pkg::dtiu_mem_s mem_out,
  output logic [15:0] mem_rdata
);
  logic [7:0] m [1024];
  wire [9:0] a = mem_out.addr[9:0];
  initial mem_rdata = 16'h0000;
  always @(posedge sys_clk) begin
    // idle bus toggles so stale data never passes as a read
    mem_rdata <= mem_out.rd ? {mem_out.word ? m[a + 10'h1] : 8'h00, m[a]} : ~mem_rdata;
    if (mem_out.wr) begin
      m[a] <= mem_out.wdata[7:0];
      if (mem_out.word) m[a + 10'h1] <= mem_out.wdata[15:8];
    end
  end
endmodule // dtiu_mem_model

/* File: tb/dtiu_monitor.sv */
// dtiu_monitor: timing and port relations of dtiu_top
// assumes bind onto every dtiu_top instance
`timescale 1ns/100ps
module dtiu_monitor #(parameter bit NARROW_BUS = 1'b0) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic op_valid,
  input dtiu_pkg::dtiu_op_s op,
  input wire logic op_ready,
  input wire logic op_done,
  input wire logic irq_inhibit,
  input dtiu_pkg::dtiu_mem_s mem_out,
  input wire logic rb_rd,
  input wire logic [15:0] rb_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire tk = op_valid && op_ready;
  wire is_seg = (op.kind == dtiu_pkg::DTIU_OP_MOV_SR || op.kind == dtiu_pkg::DTIU_OP_MOV_SM) && op.sreg != 2'h1;
  wire strobe = mem_out.rd || mem_out.wr;
  logic seg_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) seg_q <= 1'b0;
    else if (tk) seg_q <= is_seg;
  end
  a_inhib_set: assert property (op_done && seg_q |=> irq_inhibit) else $error("inhibit not raised");
  a_inhib_clear: assert property (op_done && !seg_q |=> !irq_inhibit) else $error("inhibit stuck");
  a_imm_clocks: assert property (tk && op.kind == dtiu_pkg::DTIU_OP_MOV_RI |=> (!op_done && !strobe) [*3]
    ##1 op_done) else $error("imm timing");
  a_segreg_clocks: assert property (tk && op.kind == dtiu_pkg::DTIU_OP_MOV_SR |=> !op_done ##1 op_done)
    else $error("seg timing");
  a_xch_acc: assert property (tk && op.kind == dtiu_pkg::DTIU_OP_XCH_AR |=> (!op_done && !strobe) [*2]
    ##1 op_done) else $error("acc xch timing");
  a_lookup_seq: assert property (tk && op.kind == dtiu_pkg::DTIU_OP_LOOKUP |=> !op_done ##1
    (mem_out.rd && !mem_out.word && !op_done) ##1 (!op_done) [*6] ##1 op_done) else $error("lookup timing");
  a_word_align: assert property (strobe && mem_out.word |-> !NARROW_BUS && !mem_out.addr[0])
    else $error("unsplit word access");
  a_strobe_excl: assert property (!(mem_out.rd && mem_out.wr)) else $error("rd and wr together");
  a_rdata_idle: assert property (!rb_rd |=> rb_rdata == 16'h0000) else $error("stale read data");
  c_seg: cover property (op_done && seg_q);
  c_lookup: cover property (tk && op.kind == dtiu_pkg::DTIU_OP_LOOKUP);
  c_write: cover property (mem_out.wr && mem_out.word);
endmodule // dtiu_monitor
bind dtiu_top dtiu_monitor #(.NARROW_BUS(NARROW_BUS)) mon (.sys_clk(sys_clk), .arst_n(arst_n),
  .op_valid(op_valid), .op(op), .op_ready(op_ready), .op_done(op_done), .irq_inhibit(irq_inhibit),
  .mem_out(mem_out), .rb_rd(rb_rd), .rb_rdata(rb_rdata));

/* File: tb/dtiu_top_bench.sv */
// dtiu_top_bench: directed scenarios for dtiu_top, wide bus variant
// assumes dtiu_pkg, the memory model and the monitor compiled first
`timescale 1ns/100ps
module dtiu_top_bench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic op_valid = 1'b0;
  dtiu_pkg::dtiu_op_s op = '0;
  logic op_ready, op_done, irq_inhibit, rb_wr = 1'b0, rb_rd = 1'b0;
  dtiu_pkg::dtiu_mem_s mem_out;
  logic [15:0] mem_rdata, rb_rdata, v, n, rb_wdata = 16'h0000;
  logic [3:0] rb_addr = 4'h0;
  int n_mismatch = 0;
  int n_checks = 0;
  dtiu_top #(.NARROW_BUS(1'b0)) DUT (.sys_clk(sys_clk), .arst_n(arst_n), .op_valid(op_valid), .op(op),
    .op_ready(op_ready), .op_done(op_done), .irq_inhibit(irq_inhibit), .mem_out(mem_out),
    .mem_rdata(mem_rdata), .rb_addr(rb_addr), .rb_wdata(rb_wdata), .rb_wr(rb_wr), .rb_rd(rb_rd),
    .rb_rdata(rb_rdata));
  dtiu_mem_model mem (.sys_clk(sys_clk), .mem_out(mem_out), .mem_rdata(mem_rdata));
  initial forever #12.5 sys_clk = ~sys_clk;
  task chk(input logic [23:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    rb_addr <= a;
    rb_wdata <= d;
    rb_wr <= 1'b1;
    @(posedge sys_clk);
    rb_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    rb_addr <= a;
    rb_rd <= 1'b1;
    @(posedge sys_clk);
    rb_rd <= 1'b0;
    #1 v = rb_rdata;
  endtask
  function automatic dtiu_pkg::dtiu_op_s o(dtiu_pkg::dtiu_kind_e k, logic w = 1'b0, logic [2:0] r = 3'h0,
      logic [1:0] md = 2'h0, logic [2:0] m = 3'h0, logic [1:0] s = 2'h0, logic [15:0] d = 16'h0000,
      logic [15:0] i = 16'h0000);
    return '{k, w, r, md, m, s, 1'b0, 2'h0, d, i};
  endfunction
  // n: busy cycles, done cycle included
  task run(input dtiu_pkg::dtiu_op_s x);
    @(posedge sys_clk);
    op <= x;
    op_valid <= 1'b1;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1 n = 16'h0001;
    while (op_done !== 1'b1 && n < 16'h0040) begin
      @(posedge sys_clk);
      #1 n = n + 16'h0001;
    end
  endtask
  task t_imm;
    run(o(dtiu_pkg::DTIU_OP_MOV_RI, 1'b1, 3'h1, 2'h0, 3'h0, 2'h0, 16'h0000, 16'h1234));
    chk(n, 16'h0004);
    run(o(dtiu_pkg::DTIU_OP_MOV_RI, 1'b0, 3'h4, 2'h0, 3'h0, 2'h0, 16'h0000, 16'hAA5A));
    rd(4'h0);
    chk(v, 16'h5A00);
  endtask
  task t_acc;
    mem.m[10'h200] = 8'h34;
    mem.m[10'h201] = 8'h12;
    run(o(dtiu_pkg::DTIU_OP_MOV_AD, 1'b1, 3'h0, 2'h0, 3'h6, 2'h0, 16'h0200));
    chk(n, 16'h000A);
    run(o(dtiu_pkg::DTIU_OP_MOV_AD, 1'b0, 3'h0, 2'h0, 3'h6, 2'h0, 16'h0201));
    rd(4'h0);
    chk(v, 16'h1212);
    run(o(dtiu_pkg::DTIU_OP_MOV_DA, 1'b1, 3'h0, 2'h0, 3'h6, 2'h0, 16'h0103));
    chk(n, 16'h000D);
    chk({mem.m[10'h104], mem.m[10'h103]}, 16'h1212);
  endtask
  task t_seg;
    run(o(dtiu_pkg::DTIU_OP_MOV_SR, 1'b1, 3'h1, 2'h0, 3'h1, 2'h2));
    chk(n, 16'h0002);
    rd(4'hA);
    chk({v, irq_inhibit}, 17'h02469);
    run(o(dtiu_pkg::DTIU_OP_MOV_SR, 1'b1, 3'h1, 2'h0, 3'h1, 2'h1));
    rd(4'h9);
    chk({v, irq_inhibit}, 17'h00000);
  endtask
  task t_flags;
    wr(4'hC, 16'h08D5);
    run(o(dtiu_pkg::DTIU_OP_AH_FLAGS));
    rd(4'h0);
    chk({n[7:0], v[15:8]}, 16'h02D5);
    wr(4'h0, 16'h0000);
    run(o(dtiu_pkg::DTIU_OP_FLAGS_AH));
    rd(4'hC);
    chk({n[7:0], v[11:0]}, 20'h03800);
    run(o(dtiu_pkg::DTIU_OP_MOV_RI, 1'b1, 3'h2, 2'h0, 3'h0, 2'h0, 16'h0000, 16'hFFFF));
    rd(4'hC);
    chk(v, 16'h0800);
    rd(4'hE);
    chk(v, 16'h0000);
  endtask
  task t_mem;
    wr(4'h3, 16'h0300);
    wr(4'h0, 16'h0005);
    mem.m[10'h305] = 8'h77;
    run(o(dtiu_pkg::DTIU_OP_LOOKUP));
    rd(4'h0);
    chk({n[7:0], v[7:0]}, 16'h0977);
    run(o(dtiu_pkg::DTIU_OP_XCH_MR, 1'b0, 3'h1, 2'h0, 3'h7));
    chk({n[7:0], mem.m[10'h300]}, 16'h1034);
    run(o(dtiu_pkg::DTIU_OP_LOAD_EFFECTIVE_ADDRESS_OP, 1'b1, 3'h6, 2'h2, 3'h7, 2'h0, 16'h0010));
    rd(4'h6);
    chk({n[3:0], v}, 20'h40310);
    run(o(dtiu_pkg::DTIU_OP_XCH_RR, 1'b1, 3'h1, 2'h0, 3'h6));
    rd(4'h1);
    chk({n[3:0], v}, 20'h30310);
  endtask
  task automatic t_table;
    dtiu_pkg::dtiu_kind_e ks [6] = '{dtiu_pkg::DTIU_OP_MOV_MR, dtiu_pkg::DTIU_OP_MOV_RM, dtiu_pkg::DTIU_OP_MOV_MI,
      dtiu_pkg::DTIU_OP_MOV_SM, dtiu_pkg::DTIU_OP_MOV_MS, dtiu_pkg::DTIU_OP_MOV_RS};
    logic [4:0] cs [6] = '{5'h09, 5'h0B, 5'h0B, 5'h0B, 5'h0A, 5'h02};
    for (int i = 0; i < 6; i++) begin
      run(o(ks[i], 1'b1, 3'h5, 2'h0, 3'h7, 2'h2));
      chk(n, cs[i]);
    end
  endtask
  task t_ptr;
    {mem.m[10'h404], mem.m[10'h403], mem.m[10'h402], mem.m[10'h401], mem.m[10'h400]} = 40'h9A56781234;
    run(o(dtiu_pkg::DTIU_OP_PTR_DS1, 1'b1, 3'h7, 2'h0, 3'h6, 2'h0, 16'h0400));
    rd(4'h7);
    chk({n[7:0], v}, 24'h121234);
    rd(4'h8);
    chk(v, 16'h5678);
    run(o(dtiu_pkg::DTIU_OP_PTR_DS0, 1'b1, 3'h7, 2'h0, 3'h6, 2'h0, 16'h0401));
    rd(4'hB);
    chk({n[7:0], v}, 24'h1A9A56);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_imm;
    t_acc;
    t_seg;
    t_flags;
    t_mem;
    t_table;
    t_ptr;
    end_sim;
  end
  initial begin
    #100us;
    n_mismatch++;
    end_sim;
  end
endmodule // dtiu_top_bench
